// ===== dv/quadrature_decoder_irq_asserts.sv
/* port checker for quad_decoder_irq_enable.
   assumes one-cycle strobes and the shared register map header */
`timescale 1ns/1ps
`default_nettype none
`include "quadrature_decoder_irq_regs.vh"
module quad_decoder_irq_chk (
  input wire             clk_sys,                       // clock
  input wire             rst_n,                         // reset
  input wire [`ADDR_W-1:0] reg_addr,                    // address
  input wire [`DATA_W-1:0] reg_wdata,                   // write data
  input wire             reg_wr,                        // write strobe
  input wire             reg_rd,                        // read strobe
  input wire [`DATA_W-1:0] reg_rdata,                   // read data
  input wire             sample_ready_event,            // sample pulse
  input wire [`MOTION_W-1:0] motion_accumulator,        // motion count
  input wire [`DOUBLE_W-1:0] double_transition_accumulator, // doubles
  input wire             report_ready_event,            // report pulse
  input wire             double_ready_event,            // double pulse
  input wire [`EV_COUNT-1:0] irq_enable,                // mask
  input wire             irq                            // interrupt
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire ws = reg_wr && reg_addr == `OFS_IRQ_ENABLE_SET;
  wire wc = reg_wr && reg_addr == `OFS_IRQ_ENABLE_CLEAR;
  wire rm = reg_rd && (reg_addr == `OFS_IRQ_ENABLE_SET || reg_addr == `OFS_IRQ_ENABLE_CLEAR);
  set_bit_a: assert property (
    ws |=> irq_enable == ($past(irq_enable) | $past(reg_wdata[4:0]))) else $error("set write wrong");
  clr_bit_a: assert property (
    wc |=> irq_enable == ($past(irq_enable) & ~$past(reg_wdata[4:0]))) else $error("clear write wrong");
  read_mask_a: assert property (
    rm |=> reg_rdata == {{(`DATA_W-`EV_COUNT){1'b0}}, $past(irq_enable)}) else $error("mask read wrong");
  hold_mask_a: assert property (
    !(ws || wc) |=> $stable(irq_enable)) else $error("mask changed");
  report_gate_a: assert property (
    report_ready_event |-> $past(motion_accumulator) != 0) else $error("report without motion");
  double_gate_a: assert property (
    double_ready_event |-> $past(double_transition_accumulator) != 0) else $error("double without doubles");
  irq_raise_a: assert property (
    sample_ready_event && irq_enable[0] && !reg_wr |=> irq) else $error("irq not raised");
  irq_mask_a: assert property (
    irq |-> irq_enable != 0) else $error("irq while all masked");
  rdata_idle_a: assert property (
    !reg_rd |=> reg_rdata == 0) else $error("read data not idle");
  cover property (report_ready_event);
  cover property (double_ready_event);
  cover property (irq ##1 !irq);
endmodule // quad_decoder_irq_chk
bind quad_decoder_irq_enable quad_decoder_irq_chk quad_decoder_irq_chk_inst (.clk_sys, .rst_n, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sample_ready_event, .motion_accumulator,
  .double_transition_accumulator, .report_ready_event, .double_ready_event, .irq_enable, .irq);
`default_nettype wire

// ===== dv/quadrature_decoder_irq_enable_bench.sv
/* self-checking bench for quad_decoder_irq_enable.
   assumes the shared register map header */
`timescale 1ns/1ps
`default_nettype none
`include "quadrature_decoder_irq_regs.vh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module quad_decoder_irq_enable_bench;
  logic        clk_sys = '0, rst_n = '0, reg_wr = '0, reg_rd = '0;
  logic [11:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, rd;
  logic [2:0]  ev = '0;
  logic [10:0] macc = '0;
  logic [3:0]  dacc = '0;
  wire  [31:0] reg_rdata;
  wire  [4:0]  irq_enable;
  wire         rep, dbl, irq;
  int          fail_count = 0, tests_run = 0, rep_n, dbl_n;
  // write flag, address, write data or expected read data
  logic [44:0] rows [16] = '{{1'h0, 12'h304, 32'h0}, {1'h0, 12'h308, 32'h0}, {1'h1, 12'h304, 32'h5},
    {1'h0, 12'h308, 32'h5}, {1'h1, 12'h304, 32'hFFFFFF0A}, {1'h0, 12'h304, 32'hF}, {1'h1, 12'h308, 32'h0},
    {1'h0, 12'h304, 32'hF}, {1'h1, 12'h308, 32'h6}, {1'h0, 12'h308, 32'h9}, {1'h1, 12'h304, 32'h10},
    {1'h0, 12'h304, 32'h19}, {1'h1, 12'h308, 32'h1F}, {1'h1, 12'h200, 32'h1F}, {1'h0, 12'h304, 32'h0},
    {1'h0, 12'h200, 32'h0}};
  quad_decoder_irq_enable quad_decoder_irq_enable_inst (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata,
    .sample_ready_event(ev[0]), .accumulator_overflow_event(ev[1]), .stopped_event(ev[2]),
    .motion_accumulator(macc), .double_transition_accumulator(dacc),
    .report_ready_event(rep), .double_ready_event(dbl), .irq_enable, .irq);
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (rep === 1'b1) rep_n++;
    if (dbl === 1'b1) dbl_n++;
  end
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  // n one-cycle pulses on event input k, then let the report pipeline drain
  task pulse(input int k, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      ev[k] <= 1'b1;
      @(posedge clk_sys);
      ev[k] <= 1'b0;
    end
    repeat (5) @(posedge clk_sys);
    #1;
  endtask
  task conclude;
    $display("mismatches %0d, checks %0d", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 `CHK("mask after reset", 5'h00, irq_enable)
    foreach (rows[i]) begin
      bus(rows[i][44], rows[i][43:32], rows[i][31:0]);
      if (!rows[i][44]) `CHK("register read", rows[i][31:0], rd)
    end
    bus(1'b1, `OFS_REPORT_PERIOD, 32'h1);
    bus(1'b1, `OFS_IRQ_ENABLE_SET, 32'h3);
    for (int m = 0; m < 4; m++) begin
      macc <= (m % 2) ? 11'h005 : 11'h000;
      dacc <= (m / 2) ? 4'h3 : 4'h0;
      rep_n = 0;
      dbl_n = 0;
      pulse(0, 1);
      `CHK("report count", m % 2, rep_n)
      `CHK("double count", m / 2, dbl_n)
    end
    `CHK("irq raised", 1'b1, irq)
    bus(1'b1, `OFS_IRQ_ENABLE_CLEAR, 32'h1);
    `CHK("irq from report", 1'b1, irq)
    bus(1'b1, `OFS_IRQ_ENABLE_CLEAR, 32'h2);
    `CHK("irq masked", 1'b0, irq)
    bus(1'b1, `OFS_IRQ_ENABLE_SET, 32'h2);
    `CHK("irq unmasked", 1'b1, irq)
    bus(1'b1, `OFS_EVENT_STATUS, 32'h1F);
    `CHK("irq cleared", 1'b0, irq)
    for (int k = 1; k < 3; k++) begin
      bus(1'b1, `OFS_IRQ_ENABLE_SET, 32'h1 << (2 * k));
      pulse(k, 1);
      `CHK("irq other event", 1'b1, irq)
      bus(1'b1, `OFS_IRQ_ENABLE_CLEAR, 32'h1F);
      `CHK("irq disabled", 1'b0, irq)
    end
    bus(1'b1, `OFS_REPORT_PERIOD, 32'h3);
    rep_n = 0;
    pulse(0, 2);
    `CHK("report before period", 0, rep_n)
    pulse(0, 1);
    `CHK("report at period", 1, rep_n)
    // an overflow landing on the edge of a full status clear survives
    @(posedge clk_sys);
    ev[1] <= 1'b1;
    reg_wr <= 1'b1;
    reg_addr <= `OFS_EVENT_STATUS;
    reg_wdata <= 32'h1F;
    @(posedge clk_sys);
    ev[1] <= 1'b0;
    reg_wr <= 1'b0;
    bus(1'b0, `OFS_EVENT_STATUS, 32'h0);
    `CHK("status set wins", 32'h4, rd)
    bus(1'b1, `OFS_IRQ_ENABLE_SET, 32'h4);
    `CHK("irq before reset", 1'b1, irq)
    // reset in mid-run, then reset values read back
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 `CHK("mask in reset", 5'h00, irq_enable)
    `CHK("irq in reset", 1'b0, irq)
    @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    bus(1'b0, `OFS_REPORT_PERIOD, 32'h0);
    `CHK("period after reset", `REPORT_PERIOD_RESET, rd)
    bus(1'b0, `OFS_IRQ_ENABLE_CLEAR, 32'h0);
    `CHK("mask after second reset", 32'h0, rd)
    conclude();
  end
  initial begin
    #20000;
    fail_count++;
    conclude();
  end
endmodule // quad_decoder_irq_enable_bench
`default_nettype wire

// ===== hdl/quadrature_decoder_irq_enable.v
/*
  Interrupt enable set/clear logic of the quadrature decoder, with the
  sticky event flags, report period gating and the interrupt output.
  Assumes the decoder core supplies its event pulses and accumulator
  values synchronous to clk_sys, and a register master that follows
  the one-cycle strobe protocol.
*/
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "quadrature_decoder_irq_regs.vh"

module quad_decoder_irq_enable (
  input  wire                        clk_sys,                       // 250 MHz system clock
  input  wire                        rst_n,                         // async reset, active low
  input  wire [`ADDR_W-1:0]          reg_addr,                      // register byte address
  input  wire [`DATA_W-1:0]          reg_wdata,                     // write data
  input  wire                        reg_wr,                        // write strobe
  input  wire                        reg_rd,                        // read strobe
  output reg  [`DATA_W-1:0]          reg_rdata,                     // read data, cycle after reg_rd
  input  wire                        sample_ready_event,            // pulse: new sample
  input  wire                        accumulator_overflow_event,    // pulse: accumulator overflow
  input  wire                        stopped_event,                 // pulse: decoder stopped
  input  wire [`MOTION_W-1:0]        motion_accumulator,            // motion accumulator value
  input  wire [`DOUBLE_W-1:0]        double_transition_accumulator, // double transition count
  output reg                         report_ready_event,            // pulse: report ready
  output reg                         double_ready_event,            // pulse: double ready
  output reg  [`EV_COUNT-1:0]        irq_enable,                    // current enable mask
  output reg                         irq                            // level interrupt
);

  // ------------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------------
  reg rst_meta_n;
  reg rst_sync_n;
  // deassertion is synchronised so all flops leave reset on one edge

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ------------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------------
  // only one address matches at a time, so set and clear never meet
  wire hit_set;
  wire hit_clear;
  wire hit_status;
  wire hit_period;
  wire wr_set;
  wire wr_clear;
  wire wr_status;
  wire wr_period;

  assign hit_set    = (reg_addr == `OFS_IRQ_ENABLE_SET);
  assign hit_clear  = (reg_addr == `OFS_IRQ_ENABLE_CLEAR);
  assign hit_status = (reg_addr == `OFS_EVENT_STATUS);
  assign hit_period = (reg_addr == `OFS_REPORT_PERIOD);

  assign wr_set    = reg_wr && hit_set;
  assign wr_clear  = reg_wr && hit_clear;
  assign wr_status = reg_wr && hit_status;
  assign wr_period = reg_wr && hit_period;

  // ------------------------------------------------------------------
  // report period register and timer
  // ------------------------------------------------------------------
  reg  [`PERIOD_W-1:0] report_period_count;
  wire                 period_done;

  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      report_period_count <= `REPORT_PERIOD_RESET;
    end else if (wr_period) begin
      report_period_count <= reg_wdata[`PERIOD_W-1:0];
    end
  end

  // a period of zero behaves as one sample
  report_period_timer report_period_timer_inst (
    .clk_sys       (clk_sys),
    .rst_sync_n    (rst_sync_n),
    .sample_strobe (sample_ready_event),
    .period        (report_period_count),
    .period_done   (period_done)
  );

  // ------------------------------------------------------------------
  // report and double ready generation
  // ------------------------------------------------------------------
  // the accumulators are judged one cycle after the closing sample, once
  // the decoder core has folded that sample in
  wire next_report_ready;
  wire next_double_ready;

  assign next_report_ready = period_done &&
                             (motion_accumulator != {`MOTION_W{1'b0}});            // [RQ4]
  assign next_double_ready = period_done &&
                             (double_transition_accumulator != {`DOUBLE_W{1'b0}}); // [RQ5]

  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      report_ready_event <= 1'b0;
      double_ready_event <= 1'b0;
    end else begin
      report_ready_event <= next_report_ready;
      double_ready_event <= next_double_ready;
    end
  end

  // ------------------------------------------------------------------
  // enable mask, set and clear by writing ones
  // ------------------------------------------------------------------
  reg [`EV_COUNT-1:0] next_irq_enable;
  // zero bits in either write leave their enable untouched

  always @* begin
    next_irq_enable = irq_enable;
    if (wr_set) begin
      next_irq_enable = irq_enable | reg_wdata[`EV_COUNT-1:0];  // [RQ1] [RQ6]
    end
    if (wr_clear) begin
      next_irq_enable = irq_enable & ~reg_wdata[`EV_COUNT-1:0]; // [RQ2] [RQ6]
    end
  end

  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_enable <= `IRQ_ENABLE_RESET;
    end else begin
      irq_enable <= next_irq_enable;
    end
  end

  // ------------------------------------------------------------------
  // sticky event flags, write one to clear, set wins
  // ------------------------------------------------------------------
  reg  [`EV_COUNT-1:0] event_status;
  wire [`EV_COUNT-1:0] event_hit;
  wire [`EV_COUNT-1:0] status_clr;
  wire [`EV_COUNT-1:0] next_event_status;

  assign event_hit[`EV_SAMPLE_READY] = sample_ready_event;
  assign event_hit[`EV_REPORT_READY] = report_ready_event;
  assign event_hit[`EV_OVERFLOW]     = accumulator_overflow_event;
  assign event_hit[`EV_DOUBLE_READY] = double_ready_event;
  assign event_hit[`EV_STOPPED]      = stopped_event;

  // an event on the edge of its own clear wins, so none is lost
  genvar gi;
  generate
    for (gi = 0; gi < `EV_COUNT; gi = gi + 1) begin : g_flag
      assign status_clr[gi]        = wr_status && reg_wdata[gi];
      assign next_event_status[gi] = event_hit[gi] | (event_status[gi] & ~status_clr[gi]);
    end
  endgenerate

  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      event_status <= `EVENT_STATUS_RESET;
    end else begin
      event_status <= next_event_status;
    end
  end

  // ------------------------------------------------------------------
  // interrupt output
  // ------------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq <= 1'b0;
    end else begin
      // from next state, so irq moves on the same edge as status and mask
      irq <= |(next_event_status & next_irq_enable); // [RQ6]
    end
  end

  // ------------------------------------------------------------------
  // read path, data valid only in the cycle after the strobe
  // ------------------------------------------------------------------
  reg [`DATA_W-1:0] next_rdata;

  always @* begin
    next_rdata = {`DATA_W{1'b0}};
    if (reg_rd) begin
      case (reg_addr)
        `OFS_IRQ_ENABLE_SET: begin
          next_rdata[`EV_COUNT-1:0] = irq_enable; // [RQ3]
        end
        `OFS_IRQ_ENABLE_CLEAR: begin
          next_rdata[`EV_COUNT-1:0] = irq_enable; // [RQ3]
        end
        `OFS_EVENT_STATUS: begin
          next_rdata[`EV_COUNT-1:0] = event_status;
        end
        `OFS_REPORT_PERIOD: begin
          next_rdata[`PERIOD_W-1:0] = report_period_count;
        end
        default: begin
          // unmapped addresses read as zero
          next_rdata = {`DATA_W{1'b0}};
        end
      endcase
    end
  end

  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata <= {`DATA_W{1'b0}};
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule // quad_decoder_irq_enable
`default_nettype wire

// ===== hdl/quadrature_decoder_irq_regs.vh
/*
  Register offsets, field positions, reset values and widths for the
  quadrature decoder interrupt enable block.
  Assumes a plain word-addressed register port with byte addresses.
*/
// Contract
// [RQ1] writing one to set register enables event
// [RQ2] writing one to clear register disables event
// [RQ3] both registers read back the shared enable mask
// [RQ4] report ready after period with nonzero motion
// [RQ5] double ready after period with nonzero doubles
// [RQ6] irq while flagged event enabled; zeros ignored
`ifndef QUAD_DECODER_IRQ_REGS_VH
`define QUAD_DECODER_IRQ_REGS_VH

// ----------------------------------------------------------------------
// bus geometry
// ----------------------------------------------------------------------
`define ADDR_W            12
`define DATA_W            32

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define OFS_IRQ_ENABLE_SET   12'h304
`define OFS_IRQ_ENABLE_CLEAR 12'h308
`define OFS_EVENT_STATUS     12'h400
`define OFS_REPORT_PERIOD    12'h404

// ----------------------------------------------------------------------
// event bit positions, shared by enable, status and clear registers
// ----------------------------------------------------------------------
`define EV_COUNT          5
`define EV_SAMPLE_READY   0
`define EV_REPORT_READY   1
`define EV_OVERFLOW       2
`define EV_DOUBLE_READY   3
`define EV_STOPPED        4

// ----------------------------------------------------------------------
// reset values and field widths
// ----------------------------------------------------------------------
`define IRQ_ENABLE_RESET  5'h00
`define EVENT_STATUS_RESET 5'h00
`define PERIOD_W          9
`define REPORT_PERIOD_RESET 9'h00A
`define MOTION_W          11
`define DOUBLE_W          4

`endif

// ===== hdl/report_period_timer.v
/*
  Counts decoder samples and emits a one-cycle pulse each time the
  programmed number of samples has been gathered.
  Assumes sample_strobe is a one-cycle pulse synchronous to clk_sys;
  a period of zero is treated as one sample.
*/
`timescale 1ns/1ps
`default_nettype none
`include "quadrature_decoder_irq_regs.vh"

module report_period_timer (
  input  wire                   clk_sys,       // system clock
  input  wire                   rst_sync_n,    // synchronised reset, active low
  input  wire                   sample_strobe, // one new sample taken
  input  wire [`PERIOD_W-1:0]   period,        // samples per report
  output reg                    period_done    // pulse: period gathered
);

  reg  [`PERIOD_W-1:0] sample_count;
  wire                 last_sample;

  // ------------------------------------------------------------------
  // sample counter
  // ------------------------------------------------------------------
  assign last_sample = (sample_count >= period - {{(`PERIOD_W-1){1'b0}}, 1'b1}) ||
                       (period == {`PERIOD_W{1'b0}});

  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sample_count <= {`PERIOD_W{1'b0}};
      period_done  <= 1'b0;
    end else begin
      period_done <= sample_strobe && last_sample;
      if (sample_strobe) begin
        if (last_sample) begin
          sample_count <= {`PERIOD_W{1'b0}};
        end else begin
          sample_count <= sample_count + {{(`PERIOD_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // report_period_timer
`default_nettype wire
